// ===== addr_region_decoder.sv
// Combinational address region decoder for one bus master.
// Assumes remap and boot selections are stable registered levels.
`timescale 1ns/1ps
module addr_region_decoder
  import boot_map_pkg::*;
(
  input  wire logic                  remap,
  input  wire logic                  boot_flash,
  input  wire logic                  ext_boot,
  input  wire logic                  cs1_to_sdram,
  input  wire logic [31:0]           addr,
  output boot_map_pkg::slave_t       slave,
  output logic      [2:0]            chip_sel,
  output logic      [27:0]           offset,
  output logic                       hit
);

  logic [3:0] cs_index;

  always_comb begin
    cs_index = addr[31:28] - EBI_FIRST_NIBBLE;
    slave    = SLV_NONE;
    chip_sel = CHIP_SELECT_ZERO;
    offset   = addr[27:0];
    hit      = 1'b0;
    if (addr <= BOOT_LIMIT) begin  // RULE_06
      hit    = 1'b1;
      offset = {8'h00, addr[19:0]};
      if (remap) begin
        slave = SLV_SRAM;  // RULE_02
      end else if (ext_boot) begin
        slave    = SLV_SMC;  // RULE_15
        chip_sel = CHIP_SELECT_ZERO;
        offset   = addr[27:0];
      end else if (boot_flash) begin
        slave = SLV_FLASH;  // RULE_07
      end else begin
        slave = SLV_ROM;  // RULE_08
      end
    end else if ((addr & INT_WIN_MASK) == FLASH_BASE) begin
      // Fixed windows stay live whatever aliases address zero
      hit    = 1'b1;  // RULE_10
      slave  = SLV_FLASH;
      offset = {8'h00, addr[19:0]};
    end else if ((addr & INT_WIN_MASK) == SRAM_BASE) begin
      hit    = 1'b1;  // RULE_10
      slave  = SLV_SRAM;
      offset = {8'h00, addr[19:0]};
    end else if ((addr & INT_WIN_MASK) == ROM_BASE) begin
      hit    = 1'b1;  // RULE_10
      slave  = SLV_ROM;
      offset = {8'h00, addr[19:0]};
    end else if (addr[31:28] >= EBI_FIRST_NIBBLE && addr[31:28] <= EBI_LAST_NIBBLE) begin
      // One 256 MB window per chip-select line
      hit      = 1'b1;  // RULE_11
      chip_sel = cs_index[2:0];
      if (cs_index[2:0] == CHIP_SELECT_ONE && cs1_to_sdram) begin
        slave = SLV_SDRAM;  // RULE_12
      end else begin
        slave = SLV_SMC;  // RULE_12
      end
    end else if (addr >= SYSC_BASE && addr <= SYSC_LIMIT) begin
      hit    = 1'b1;  // RULE_13
      slave  = SLV_SYSC;
    end
  end

endmodule

// ===== boot_map_pkg.sv
// Constants and types shared by the boot remap address decoder.
// Assumes a 32-bit byte address space and one decoder per bus master.
package boot_map_pkg;

  // ----------------------------------------------------------------
  // Slave and phase enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SLV_NONE,
    SLV_ROM,
    SLV_FLASH,
    SLV_SRAM,
    SLV_SMC,
    SLV_SDRAM,
    SLV_SYSC
  } slave_t;

  typedef enum logic [1:0] {
    PH_CAPTURE,
    PH_SLOW,
    PH_MAIN
  } phase_t;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] BOOT_BASE        = 32'h0000_0000;
  localparam logic [31:0] BOOT_LIMIT       = 32'h0FFF_FFFF;
  localparam logic [31:0] FLASH_BASE       = 32'h1020_0000;
  localparam logic [31:0] SRAM_BASE        = 32'h1030_0000;
  localparam logic [31:0] ROM_BASE         = 32'h1040_0000;
  localparam logic [31:0] INT_WIN_MASK     = 32'hFFF0_0000;
  localparam logic [31:0] CS_WINDOW_BYTES  = 32'h1000_0000;
  localparam logic [3:0]  EBI_FIRST_NIBBLE = 4'h2;
  localparam logic [3:0]  EBI_LAST_NIBBLE  = 4'h9;
  localparam logic [31:0] SYSC_BASE        = 32'hFFFF_E800;
  localparam logic [31:0] SYSC_LIMIT       = 32'hFFFF_FFFF;
  localparam logic [2:0]  CHIP_SELECT_ZERO = 3'h0;
  localparam logic [2:0]  CHIP_SELECT_ONE  = 3'h1;

  // ----------------------------------------------------------------
  // Reset values and misc
  // ----------------------------------------------------------------
  localparam logic        REMAP_RESET      = 1'b0;
  localparam logic        BOOT_SEL_RESET   = 1'b0;
  localparam int          SLOW_CLK_HZ      = 32768;
  localparam int          MASTER_COUNT     = 2;

endpackage

// ===== boot_remap_address_decoder.sv
// Boot remap address decoder: picks the memory seen at address zero for
// the instruction and data masters, and places external and system windows.
// Assumes requests are synchronous to sys_clk; remap writes arrive as pulses.
//
// Behaviour
// RULE_01: First fetch at address zero goes to the currently selected boot memory.
// RULE_02: Remap set puts the first SRAM bank at address zero, ignoring boot bit.
// RULE_03: Software sets remap after booting; run-time remap writes take effect.
// RULE_04: Remap clear lets the stored boot bit choose ROM or Flash at zero.
// RULE_05: Boot selection is caught at reset and held until the next reset.
// RULE_06: Whole region from zero to the boot limit is the boot alias.
// RULE_07: Boot bit set and remap clear maps internal Flash at zero.
// RULE_08: Boot bit clear and remap clear maps embedded ROM at zero.
// RULE_09: Erased boot bit selects embedded ROM at the next reset.
// RULE_10: Every memory stays reachable at its fixed base in all settings.
// RULE_11: Each external chip-select line owns its own 256 MB window.
// RULE_12: Chip-select one may go to SDRAM or static; zero only static.
// RULE_13: System controller base to address top goes to system controller.
// RULE_14: Out of reset run on slow clock from RC or crystal oscillator.
// RULE_15: Address zero has internal boot, external boot and remapped slaves.
// RULE_16: Remap control clears on every reset.
`timescale 1ns/1ps
module boot_remap_address_decoder
  import boot_map_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  boot_source_nv_bit,
  input  wire logic                  ext_boot_strap,
  input  wire logic                  osc_xtal_select,
  input  wire logic                  remap_set,
  input  wire logic                  remap_clear,
  input  wire logic                  cs1_sdram_assign,
  input  wire logic                  main_clock_switch,
  input  wire logic                  inst_req,
  input  wire logic [31:0]           inst_addr,
  input  wire logic                  data_req,
  input  wire logic [31:0]           data_addr,
  output logic                       inst_valid,
  output logic                       inst_error,
  output boot_map_pkg::slave_t       inst_slave,
  output logic      [2:0]            inst_chip_select,
  output logic      [27:0]           inst_offset,
  output logic                       data_valid,
  output logic                       data_error,
  output boot_map_pkg::slave_t       data_slave,
  output logic      [2:0]            data_chip_select,
  output logic      [27:0]           data_offset,
  output logic                       remap_active,
  output logic                       boot_from_flash,
  output logic                       boot_external,
  output logic                       run_on_slow_clock,
  output logic                       slow_clock_from_xtal,
  output logic                       decode_ready
);

  import boot_map_pkg::*;

  // ----------------------------------------------------------------
  // Boot phase, captured boot selection and remap control
  // ----------------------------------------------------------------
  phase_t phase;
  phase_t next_phase;
  logic   boot_flash;
  logic   next_boot_flash;
  logic   ext_boot;
  logic   next_ext_boot;
  logic   remap;
  logic   next_remap;
  logic   slow_run;
  logic   next_slow_run;
  logic   xtal_src;
  logic   next_xtal_src;

  always_comb begin
    next_phase      = phase;
    next_boot_flash = boot_flash;
    next_ext_boot   = ext_boot;
    next_slow_run   = slow_run;
    next_xtal_src   = xtal_src;
    case (phase)
      PH_CAPTURE: begin
        // The strap is sampled by the clock after release, never by the
        // asynchronous reset itself; later changes are ignored.
        next_boot_flash = boot_source_nv_bit;  // RULE_05
        next_ext_boot   = ext_boot_strap;      // RULE_05
        next_xtal_src   = osc_xtal_select;     // RULE_14
        next_slow_run   = 1'b1;                // RULE_14
        next_phase      = PH_SLOW;
      end
      PH_SLOW: begin
        // Boot code must switch clocks itself; stay slow until told
        if (main_clock_switch) begin
          next_slow_run = 1'b0;
          next_phase    = PH_MAIN;
        end
      end
      PH_MAIN: begin
        next_phase = PH_MAIN;
      end
      default: begin
        next_phase = PH_CAPTURE;
      end
    endcase
  end

  always_comb begin
    next_remap = remap;
    // Set wins when both pulses meet in one cycle
    if (remap_set) begin
      next_remap = 1'b1;  // RULE_03
    end else if (remap_clear) begin
      next_remap = 1'b0;  // RULE_04
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase      <= PH_CAPTURE;
      boot_flash <= BOOT_SEL_RESET;  // RULE_09
      ext_boot   <= 1'b0;
      remap      <= REMAP_RESET;     // RULE_16
      slow_run   <= 1'b1;            // RULE_14
      xtal_src   <= 1'b0;
    end else begin
      phase      <= next_phase;
      boot_flash <= next_boot_flash;
      ext_boot   <= next_ext_boot;
      remap      <= next_remap;
      slow_run   <= next_slow_run;
      xtal_src   <= next_xtal_src;
    end
  end

  logic ready;
  assign ready = (phase != PH_CAPTURE);

  // ----------------------------------------------------------------
  // Per-master decode and registered answer
  // ----------------------------------------------------------------
  logic        req_vec   [MASTER_COUNT];
  logic [31:0] addr_vec  [MASTER_COUNT];
  logic        valid_q   [MASTER_COUNT];
  logic        error_q   [MASTER_COUNT];
  slave_t      slave_q   [MASTER_COUNT];
  logic [2:0]  cs_q      [MASTER_COUNT];
  logic [27:0] offset_q  [MASTER_COUNT];

  assign req_vec[0]  = inst_req;
  assign addr_vec[0] = inst_addr;
  assign req_vec[1]  = data_req;
  assign addr_vec[1] = data_addr;

  genvar m;
  generate
    for (m = 0; m < MASTER_COUNT; m = m + 1) begin : g_master
      slave_t      dec_slave;
      logic [2:0]  dec_cs;
      logic [27:0] dec_offset;
      logic        dec_hit;
      logic        next_valid;
      logic        next_error;
      slave_t      next_slave;
      logic [2:0]  next_cs;
      logic [27:0] next_offset;

      // Both processor masters see the same three candidates at zero
      addr_region_decoder u_dec (  // RULE_15
        .remap        (remap),
        .boot_flash   (boot_flash),
        .ext_boot     (ext_boot),
        .cs1_to_sdram (cs1_sdram_assign),
        .addr         (addr_vec[m]),
        .slave        (dec_slave),
        .chip_sel     (dec_cs),
        .offset       (dec_offset),
        .hit          (dec_hit)
      );

      always_comb begin
        next_valid  = 1'b0;
        next_error  = 1'b0;
        next_slave  = slave_q[m];
        next_cs     = cs_q[m];
        next_offset = offset_q[m];
        // Requests before the boot selection is captured get no answer, so the first fetch at
        // zero can never hit a stale default mapping.
        if (req_vec[m] && ready) begin  // RULE_01
          next_valid  = dec_hit;
          next_error  = !dec_hit;
          next_slave  = dec_slave;
          next_cs     = dec_cs;
          next_offset = dec_offset;
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          valid_q[m]  <= 1'b0;
          error_q[m]  <= 1'b0;
          slave_q[m]  <= SLV_NONE;
          cs_q[m]     <= CHIP_SELECT_ZERO;
          offset_q[m] <= 28'h0000000;
        end else begin
          valid_q[m]  <= next_valid;
          error_q[m]  <= next_error;
          slave_q[m]  <= next_slave;
          cs_q[m]     <= next_cs;
          offset_q[m] <= next_offset;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign inst_valid           = valid_q[0];
  assign inst_error           = error_q[0];
  assign inst_slave           = slave_q[0];
  assign inst_chip_select     = cs_q[0];
  assign inst_offset          = offset_q[0];
  assign data_valid           = valid_q[1];
  assign data_error           = error_q[1];
  assign data_slave           = slave_q[1];
  assign data_chip_select     = cs_q[1];
  assign data_offset          = offset_q[1];
  assign remap_active         = remap;
  assign boot_from_flash      = boot_flash;
  assign boot_external        = ext_boot;
  assign run_on_slow_clock    = slow_run;
  assign slow_clock_from_xtal = xtal_src;

  logic ready_q;
  logic next_ready_q;

  always_comb begin
    next_ready_q = ready;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= next_ready_q;
    end
  end

  // Lags the internal ready by one cycle; masters may rely on it safely
  assign decode_ready = ready_q;

endmodule

// ===== boot_remap_address_decoder_chk.sv
// Checker for the boot remap address decoder, bound to its top module.
// Assumes single clock domain sys_clk with active-low asynchronous reset.
`timescale 1ns/1ps
module boot_remap_address_decoder_chk
  import boot_map_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst_n,
  input wire logic         cs1_sdram_assign,
  input wire logic         inst_req,
  input wire logic [31:0]  inst_addr,
  input wire logic         data_req,
  input wire logic [31:0]  data_addr,
  input wire logic         inst_valid,
  input wire logic         inst_error,
  input wire slave_t       inst_slave,
  input wire slave_t       data_slave,
  input wire logic [2:0]   data_chip_select,
  input wire logic [27:0]  data_offset,
  input wire logic         remap_active,
  input wire logic         boot_from_flash,
  input wire logic         boot_external,
  input wire logic         run_on_slow_clock,
  input wire logic         decode_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_answer_once: assert property (inst_req && decode_ready |=> inst_valid != inst_error)
    else $error("request not answered once");
  a_remap_zero: assert property (inst_req && decode_ready && remap_active
    && inst_addr[31:28] == 4'h0 |=> inst_slave == SLV_SRAM) else $error("zero not SRAM");
  a_boot_zero: assert property (inst_req && decode_ready && !remap_active && !boot_external
    && inst_addr[31:28] == 4'h0 |=> inst_slave == (boot_from_flash ? SLV_FLASH : SLV_ROM))
    else $error("zero not boot memory");
  a_boot_hold: assert property (decode_ready |=> $stable(boot_from_flash))
    else $error("boot choice moved");
  a_remap_reset: assert property ($rose(rst_n) |-> !remap_active && run_on_slow_clock)
    else $error("bad state after reset");
  a_fixed_rom: assert property (inst_req && decode_ready && inst_addr[31:20] == 12'h104
    |=> inst_slave == SLV_ROM) else $error("fixed window lost");
  a_cs_window: assert property (data_req && decode_ready && data_addr[31:28] inside {[4'h2:4'h9]}
    |=> data_chip_select == $past(data_addr[30:28]) + 3'h6 && data_offset == $past(data_addr[27:0]))
    else $error("chip-select window wrong");
  a_cs1_route: assert property (data_req && decode_ready && data_addr[31:28] == 4'h3
    |=> data_slave == ($past(cs1_sdram_assign) ? SLV_SDRAM : SLV_SMC)) else $error("cs1 route");
  a_sysc_route: assert property (data_req && decode_ready && data_addr >= SYSC_BASE
    |=> data_slave == SLV_SYSC) else $error("system window wrong");
endmodule

bind boot_remap_address_decoder boot_remap_address_decoder_chk chk_i (.sys_clk, .rst_n,
  .cs1_sdram_assign, .inst_req, .inst_addr, .data_req, .data_addr, .inst_valid, .inst_error,
  .inst_slave, .data_slave, .data_chip_select, .data_offset, .remap_active, .boot_from_flash,
  .boot_external, .run_on_slow_clock, .decode_ready);

// ===== bus_master_model.sv
// Processor instruction or data master: one request per cycle while go is high.
// Assumes go and next_addr change just after the rising edge of sys_clk.
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [31:0] next_addr,
  output logic             req,
  output logic [31:0]      addr
);
  // Idle address is inverted each cycle so a stale value is never a valid request
  always_ff @(posedge sys_clk) begin
    req  <= go;
    addr <= go ? next_addr : ~addr;
  end
endmodule

// ===== test_boot_remap_address_decoder.sv
// Self-checking bench: two master models, a reference decode model, straps per reset.
// Assumes the decoder answers exactly one cycle after each taken request.
`timescale 1ns/1ps
module test_boot_remap_address_decoder;
  import boot_map_pkg::*;
  logic sys_clk = 0, rst_n = 0, boot_source_nv_bit = 0, ext_boot_strap = 0, osc_xtal_select = 0;
  logic remap_set = 0, remap_clear = 0, cs1_sdram_assign = 0, main_clock_switch = 0, go = 0;
  logic [31:0] na_i = 0, na_d = 0, inst_addr, data_addr;
  logic inst_req, data_req, inst_valid, inst_error, data_valid, data_error, remap_active;
  logic boot_from_flash, boot_external, run_on_slow_clock, slow_clock_from_xtal, decode_ready;
  slave_t inst_slave, data_slave;
  logic [2:0] inst_chip_select, data_chip_select;
  logic [27:0] inst_offset, data_offset;
  logic [35:0] qi[$], qd[$];
  int err_total = 0, n_compared = 0, k;
  bit live = 0, m_remap, m_flash, m_ext;

  always #2.5 sys_clk = ~sys_clk;

  bus_master_model m_i (.sys_clk, .go, .next_addr(na_i), .req(inst_req), .addr(inst_addr));
  bus_master_model m_d (.sys_clk, .go, .next_addr(na_d), .req(data_req), .addr(data_addr));
  boot_remap_address_decoder DUT (.sys_clk, .rst_n, .boot_source_nv_bit, .ext_boot_strap,
    .osc_xtal_select, .remap_set, .remap_clear, .cs1_sdram_assign, .main_clock_switch,
    .inst_req, .inst_addr, .data_req, .data_addr, .inst_valid, .inst_error, .inst_slave,
    .inst_chip_select, .inst_offset, .data_valid, .data_error, .data_slave, .data_chip_select,
    .data_offset, .remap_active, .boot_from_flash, .boot_external, .run_on_slow_clock,
    .slow_clock_from_xtal, .decode_ready);

  function automatic logic [35:0] model(input logic [31:0] a);
    logic [2:0] s, c;
    logic [27:0] o;
    logic e;
    s = SLV_NONE; c = 3'h0; o = a[27:0]; e = 1'b0;
    if (a[31:28] == 4'h0) begin
      s = m_remap ? SLV_SRAM : m_ext ? SLV_SMC : m_flash ? SLV_FLASH : SLV_ROM;
      if (s != SLV_SMC) o = {8'h00, a[19:0]};
    end else if (a[31:20] >= 12'h102 && a[31:20] <= 12'h104) begin
      s = a[21:20] == 2'h2 ? SLV_FLASH : a[21:20] == 2'h3 ? SLV_SRAM : SLV_ROM;
      o = {8'h00, a[19:0]};
    end else if (a[31:28] >= 4'h2 && a[31:28] <= 4'h9) begin
      c = 3'(a[31:28] - 4'h2);
      s = (c == 3'h1 && cs1_sdram_assign) ? SLV_SDRAM : SLV_SMC;
    end else if (a >= 32'hFFFF_E800) s = SLV_SYSC;
    else e = 1'b1;
    return {e, !e, s, c, o};
  endfunction

  function automatic logic [31:0] pick();
    logic [31:0] a;
    a = $urandom;
    case (a[3:0])
      4'h0: a[31:28] = 4'h0;
      4'h1: a[31:20] = 12'h102;
      4'h2: a[31:20] = 12'h103;
      4'h3: a[31:20] = 12'h104;
      4'h4: a[31:8] = 24'hFFFFE8;
      4'h5: a[31:8] = 24'hFFFFE7;
      default: ;
    endcase
    return a;
  endfunction

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    logic [35:0] m;
    m = exp[35] ? 36'hF_8000_0000 : '1;
    check(got & m, exp & m);
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Each answer is due one edge after its request; sampled mid-cycle where all is settled
  always @(negedge sys_clk) begin
    if (qi.size() > 0) cmp({inst_error, inst_valid, inst_slave, inst_chip_select, inst_offset},
      qi.pop_front());
    if (qd.size() > 0) cmp({data_error, data_valid, data_slave, data_chip_select, data_offset},
      qd.pop_front());
    if (live && inst_req) qi.push_back(model(inst_addr));
    if (live && data_req) qd.push_back(model(data_addr));
  end

  task automatic burst(input int n);
    @(posedge sys_clk);
    cs1_sdram_assign <= 1'($urandom);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      go <= 1'b1;
      na_i <= pick();
      na_d <= pick();
    end
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // 0 remap set, 1 remap clear, 2 clock switch, 3 set and clear together
  task automatic pulse(input int sel);
    @(posedge sys_clk);
    if (sel == 0 || sel == 3) remap_set <= 1'b1;
    if (sel == 1 || sel == 3) remap_clear <= 1'b1;
    if (sel == 2) main_clock_switch <= 1'b1;
    @(posedge sys_clk);
    remap_set <= 1'b0;
    remap_clear <= 1'b0;
    main_clock_switch <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  initial begin
    void'($urandom(32'h7b8f1bd3));
    for (int r = 0; r < 4; r++) begin
      m_flash = r[0]; m_ext = (r == 3); m_remap = 0; live = 0;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      boot_source_nv_bit <= m_flash;
      ext_boot_strap <= m_ext;
      osc_xtal_select <= !m_flash;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (k = 0; k < 10 && decode_ready !== 1'b1; k++) begin
        @(posedge sys_clk);
        #1;
      end
      check(36'(k), 36'd2);
      if (k == 10) end_of_test();
      check(36'({remap_active, run_on_slow_clock, boot_from_flash, boot_external,
        slow_clock_from_xtal}), 36'({2'b01, m_flash, m_ext, !m_flash}));
      boot_source_nv_bit <= !m_flash;
      live = 1;
      burst(24);
      pulse(0);
      check(36'(remap_active), 36'h1);
      m_remap = 1;
      burst(16);
      pulse(1);
      m_remap = 0;
      burst(16);
      pulse(2);
      check(36'(run_on_slow_clock), 36'h0);
      // Set wins over clear, and the next reset must still drop the remap
      pulse(3);
      check(36'(remap_active), 36'h1);
    end
    end_of_test();
  end
endmodule
